// ==== sfsr_cmd.sv ====
/*
  Command interpreter for write-enable controls, status register access
  and single, fast and dual-output array reads of a serial flash.
  Assumes chip select, serial clock and line zero arrive asynchronously
  and are oversampled; array bytes come from a fetch port answering in
  the system clock domain within two cycles of a request.
*/
`timescale 1ns/1ps

module sfsr_cmd #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  cs_n,
  input  wire logic                  sck,
  input  wire logic                  io0_in,
  output logic                       io0_out,
  output logic                       io0_oe,
  output logic                       io1_out,
  output logic                       io1_oe,
  input  wire logic                  four_wire_command_mode,
  input  wire logic                  ext_busy,
  input  wire logic                  ext_done,
  output sfsr_pkg::sfsr_fetch_s      fetch,
  input  wire logic                  fetch_valid,
  input  wire logic [7:0]            fetch_data,
  output logic                       write_enable_latch,
  output logic                       busy,
  output logic                       quad_enable
);
  import sfsr_pkg::*;

  // Pin synchronisers; first stage feeds only the second
  logic cs_m, cs_s, cs_d;
  logic sck_m, sck_s, sck_d;
  logic io0_m, io0_s;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cs_m  <= 1'b1;
      cs_s  <= 1'b1;
      cs_d  <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      io0_m <= 1'b0;
      io0_s <= 1'b0;
    end else begin
      cs_m  <= cs_n;
      cs_s  <= cs_m;
      cs_d  <= cs_s;
      sck_m <= sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      io0_m <= io0_in;
      io0_s <= io0_m;
    end
  end

  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  assign selected = !cs_s;
  assign sck_rise = selected && sck_s && !sck_d;
  assign sck_fall = selected && !sck_s && sck_d;
  assign cs_rise  = cs_s && !cs_d;

  sfsr_state_e state;
  sfsr_state_e next_state;
  logic [4:0]  cnt;
  logic [7:0]  opcode;
  logic [7:0]  next_opcode;
  logic [23:0] addr_in;
  logic [15:0] data_in;
  logic [4:0]  dummy_qpi;
  logic [4:0]  dummy_need;
  logic        sw_busy;
  logic        busy_now;

  assign busy_now    = sw_busy || ext_busy;
  assign next_opcode = {opcode[6:0], io0_s};

  always_comb begin
    case (next_opcode)
      OP_READ_SR1, OP_READ_SR2: next_state = ST_OUT;
      OP_READ, OP_FAST_READ, OP_DUAL_READ: begin
        // Array reads never disturb a timed cycle
        next_state = busy_now ? ST_IGNORE : ST_ADDR;
      end
      OP_WRITE_SR, OP_WRITE_SR2, OP_SET_PARAM: next_state = ST_DATA;
      default: next_state = ST_IGNORE;
    endcase
  end

  always_comb begin
    if (opcode == OP_FAST_READ && four_wire_command_mode) begin
      dummy_need = dummy_qpi;
    end else begin
      dummy_need = DUMMY_SERIAL;
    end
  end

  // Frame decoder, sampling on serial clock rising edges
  always_ff @(posedge clock) begin
    if (!reset_n || !selected) begin
      // Values stay put during the deselect cycle for execution
      if (!reset_n || !cs_rise) begin
        state <= ST_OPCODE;
        cnt   <= '0;
      end
    end else if (sck_rise) begin
      case (state)
        ST_OPCODE: begin
          opcode <= next_opcode;
          cnt    <= cnt + 5'h01;
          if (cnt == OPCODE_BITS - 5'h01) begin
            cnt   <= '0;
            state <= next_state;
          end
        end
        ST_ADDR: begin
          addr_in <= {addr_in[22:0], io0_s};
          cnt     <= cnt + 5'h01;
          if (cnt == ADDR_BITS - 5'h01) begin
            cnt   <= '0;
            state <= (opcode == OP_READ) ? ST_OUT : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          cnt <= cnt + 5'h01;
          if (cnt == dummy_need - 5'h01) begin
            cnt   <= '0;
            state <= ST_OUT;
          end
        end
        ST_DATA: begin
          data_in <= {data_in[14:0], io0_s};
          if (cnt != COUNT_SATURATE) begin
            cnt <= cnt + 5'h01;
          end
        end
        ST_IGNORE: begin
          if (cnt != COUNT_SATURATE) begin
            cnt <= cnt + 5'h01;
          end
        end
        ST_OUT: begin
          cnt <= cnt;
        end
        default: state <= ST_OPCODE;
      endcase
    end
  end

  // Commands that act when chip select rises
  logic single;
  logic data8;
  logic data16;
  logic frame_done;
  logic exec_write_enable_command;
  logic exec_wrdi;
  logic exec_vol;
  logic exec_rst_en;
  logic exec_rst;
  logic exec_param;
  logic wsr_ok;
  logic vol_write;
  logic nv_start;
  logic timer_done;
  logic vol_arm;
  logic rst_arm;
  logic [15:0] timer;

  assign single = cs_rise && state == ST_IGNORE && cnt == '0;
  assign data8  = cs_rise && state == ST_DATA && cnt == DATA_BITS_SHORT;
  assign data16 = cs_rise && state == ST_DATA && cnt == DATA_BITS_LONG;
  assign frame_done  = cs_rise && state != ST_OPCODE;
  assign exec_write_enable_command   = single && opcode == OP_WRITE_ENABLE;
  assign exec_wrdi   = single && opcode == OP_WRITE_DISABLE;
  assign exec_vol    = single && opcode == OP_VOL_ENABLE;
  assign exec_rst_en = single && opcode == OP_RESET_ENABLE;
  assign exec_rst    = single && opcode == OP_RESET && rst_arm;
  assign exec_param  = data8 && opcode == OP_SET_PARAM &&
                       four_wire_command_mode;
  // Other deselect points drop the write
  assign wsr_ok = (opcode == OP_WRITE_SR && (data8 || data16)) ||
                  (opcode == OP_WRITE_SR2 && data8);
  assign vol_write  = wsr_ok && vol_arm;
  assign nv_start   = wsr_ok && !vol_arm && write_enable_latch &&
                      !busy_now;
  assign timer_done = sw_busy && timer == '0;

  sfsr_prot_s nv;
  sfsr_prot_s vol;
  sfsr_prot_s staged;
  sfsr_prot_s next_prot;

  // Pause and reserved positions of the payload are never stored
  always_comb begin
    next_prot = vol;
    if (opcode == OP_WRITE_SR2) begin
      next_prot.protect_invert    = data_in[SR2_INVERT];
      next_prot.quad_enable       = data_in[SR2_QUAD];
      next_prot.protect_lock_high = data_in[SR2_LOCK_HIGH];
    end else if (cnt == DATA_BITS_SHORT) begin
      next_prot.protect_lock_low  = data_in[SR1_LOCK_LOW];
      next_prot.protect_invert    = 1'b0;
      next_prot.quad_enable       = 1'b0;
      next_prot.protect_lock_high = 1'b0;
    end else begin
      // Invert bit is outside the reach of a sixteen-bit 01h
      next_prot.protect_lock_low  = data_in[WIDE_LOCK_LOW];
      next_prot.quad_enable       = data_in[WIDE_QUAD];
      next_prot.protect_lock_high = data_in[WIDE_LOCK_HIGH];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sw_busy <= 1'b0;
      timer   <= '0;
      staged  <= PROT_RESET;
    end else if (nv_start) begin
      sw_busy <= 1'b1;
      timer   <= STATUS_WRITE_CYCLES - 16'h0001;
      staged  <= next_prot;
    end else if (sw_busy) begin
      if (timer == '0) begin
        sw_busy <= 1'b0;
      end else begin
        timer <= timer - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nv  <= PROT_RESET;
      vol <= PROT_RESET;
    end else if (timer_done) begin
      nv  <= staged;
      vol <= staged;
    end else if (vol_write) begin
      vol <= next_prot;
    end
  end

  // Latch set by 06h wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
    end else if (exec_write_enable_command) begin
      write_enable_latch <= 1'b1;
    end else if (exec_wrdi || ext_done || timer_done) begin
      write_enable_latch <= 1'b0;
    end else if (nv_start) begin
      write_enable_latch <= 1'b0;
    end
  end

  // 50h does not touch the latch
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      vol_arm <= 1'b0;
      rst_arm <= 1'b0;
    end else begin
      if (exec_vol) begin
        vol_arm <= 1'b1;
      end else if (frame_done) begin
        vol_arm <= 1'b0;
      end
      if (exec_rst_en) begin
        rst_arm <= 1'b1;
      end else if (frame_done) begin
        rst_arm <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || exec_rst) begin
      dummy_qpi <= DUMMY_QPI_RESET;
    end else if (exec_param) begin
      case (data_in[PARAM_DUMMY_LSB +: 2])
        2'h0:    dummy_qpi <= DUMMY_QPI_SHORT;
        2'h1:    dummy_qpi <= DUMMY_QPI_MID;
        default: dummy_qpi <= DUMMY_QPI_LONG;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_now;
    end
  end

  assign quad_enable = vol.quad_enable;

  // Array prefetch into the FIFO, one request outstanding
  logic        fetch_on;
  logic        pending;
  logic        stale;
  logic        addr_done;
  logic        push_ready;
  logic        pop;
  logic        head_valid;
  logic [7:0]  head_data;

  assign addr_done = sck_rise && state == ST_ADDR &&
                     cnt == ADDR_BITS - 5'h01;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fetch    <= '0;
      fetch_on <= 1'b0;
      pending  <= 1'b0;
      stale    <= 1'b0;
    end else begin
      fetch.req <= 1'b0;
      if (fetch_valid) begin
        pending <= 1'b0;
        if (!stale) begin
          fetch.addr <= fetch.addr + 24'h00_0001;
        end
      end
      stale <= cs_rise && pending && !fetch_valid ? 1'b1 :
               fetch_valid ? 1'b0 : stale;
      if (addr_done) begin
        fetch_on   <= 1'b1;
        fetch.addr <= {addr_in[22:0], io0_s};
      end else if (cs_rise) begin
        fetch_on <= 1'b0;
      end else if (fetch_on && !pending && push_ready) begin
        // Ready low holds fetching off until a byte drains
        fetch.req <= 1'b1;
        pending   <= 1'b1;
      end
    end
  end

  sfsr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .flush     (cs_rise),
    .in_valid  (fetch_valid && !stale && fetch_on),
    .in_ready  (push_ready),
    .in_data   (fetch_data),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head_data)
  );

  // Output shifter, driving on serial clock falling edges
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] src_byte;
  logic [7:0] shift;
  logic [2:0] out_left;
  logic       is_status;
  logic       dual;

  always_comb begin
    sr1 = '0;
    sr1[SR1_BUSY]     = busy_now;
    sr1[SR1_WEL_POS]  = write_enable_latch;
    sr1[SR1_LOCK_LOW] = vol.protect_lock_low;
    // Pause and reserved bits read as zero
    sr2 = '0;
    sr2[SR2_LOCK_HIGH] = vol.protect_lock_high;
    sr2[SR2_QUAD]      = vol.quad_enable;
    sr2[SR2_INVERT]    = vol.protect_invert;
  end

  assign is_status = opcode == OP_READ_SR1 || opcode == OP_READ_SR2;
  assign dual      = opcode == OP_DUAL_READ;
  assign pop = sck_fall && state == ST_OUT && out_left == '0 &&
               !is_status;

  always_comb begin
    if (is_status) begin
      src_byte = (opcode == OP_READ_SR2) ? sr2 : sr1;
    end else begin
      // Underrun sends zeros rather than stalling the host
      src_byte = head_valid ? head_data : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n || !selected) begin
      io0_out  <= 1'b0;
      io0_oe   <= 1'b0;
      io1_out  <= 1'b0;
      io1_oe   <= 1'b0;
      shift    <= '0;
      out_left <= '0;
    end else if (sck_fall && state == ST_OUT) begin
      io1_oe <= 1'b1;
      io0_oe <= dual;
      if (out_left == '0) begin
        // Status byte reloads each time, so it repeats
        io1_out <= src_byte[7];
        io0_out <= dual ? src_byte[6] : 1'b0;
        if (dual) begin
          shift    <= {src_byte[5:0], 2'b00};
          out_left <= BITS_AFTER_TWO;
        end else begin
          shift    <= {src_byte[6:0], 1'b0};
          out_left <= BITS_AFTER_ONE;
        end
      end else begin
        io1_out <= shift[7];
        io0_out <= dual ? shift[6] : 1'b0;
        if (dual) begin
          shift    <= {shift[5:0], 2'b00};
          out_left <= out_left - 3'h2;
        end else begin
          shift    <= {shift[6:0], 1'b0};
          out_left <= out_left - 3'h1;
        end
      end
    end
  end

endmodule : sfsr_cmd

// ==== sfsr_pkg.sv ====
/*
  Constants and types for the serial flash status and read command block:
  opcodes, bit counts, status bit positions, reset values and timing.
  Assumes a 10 MHz system clock, much faster than the host serial clock.
*/
// Operation
// - Opcode 50h arms volatile status writing; write enable latch unchanged.
// - 50h directly before 01h writes volatile copies only; stored cells kept.
// - Quad mode volatile write: pause and reserved bits driven high, ignored.
// - Opcode 04h framed by chip select clears the write enable latch.
// - Write enable latch is 0 after power-up and after program, erase, writes.
// - Status reads 05h and 35h are accepted any time, even while busy.
// - Status byte shifts out MSB first on falling edges until deselect.
// - 01h with sixteen data bits changes only protect_lock_low, quad_enable and protect_lock_high.
// - Status write runs only with the latch set; host sends 06h first.
// - Status write dropped unless deselect follows data bit eight or sixteen.
// - 01h with eight data bits clears protect_invert, quad_enable, lock high.
// - Valid status write starts a timed cycle; busy 1 during, 0 after.
// - Write enable latch clears as busy rises for a status write.
// - 31h writes one byte: only protect_invert, quad_enable, lock high.
// - Read 03h: 24-bit address on rising edges; data MSB first on falling.
// - Read address increments per byte; data streams until chip select rises.
// - Read 03h while busy is ignored; the running cycle is unaffected.
// - Fast read 0Bh: address on rising edges, dummy clocks, data on falling.
// - Quad mode fast read uses 4, 6 or 8 dummy clocks from C0h bits 5:4.
// - Quad mode dummy count returns to 4 at power-up and reset instruction.
// - Dual read 3Bh: eight dummy clocks after address, two bits per clock.
// - Dual output: line zero bits 6,4,2,0; line one bits 7,5,3,1.

package sfsr_pkg;

  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_VOL_ENABLE    = 8'h50;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_SR1      = 8'h05;
  localparam logic [7:0] OP_READ_SR2      = 8'h35;
  localparam logic [7:0] OP_WRITE_SR      = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2     = 8'h31;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ     = 8'h3B;
  localparam logic [7:0] OP_SET_PARAM     = 8'hC0;
  localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
  localparam logic [7:0] OP_RESET         = 8'h99;

  localparam logic [4:0] OPCODE_BITS     = 5'h08;
  localparam logic [4:0] ADDR_BITS       = 5'h18;
  localparam logic [4:0] DATA_BITS_SHORT = 5'h08;
  localparam logic [4:0] DATA_BITS_LONG  = 5'h10;
  localparam logic [4:0] COUNT_SATURATE  = 5'h1F;
  localparam logic [4:0] DUMMY_SERIAL    = 5'h08;
  localparam logic [4:0] DUMMY_QPI_SHORT = 5'h04;
  localparam logic [4:0] DUMMY_QPI_MID   = 5'h06;
  localparam logic [4:0] DUMMY_QPI_LONG  = 5'h08;
  localparam logic [4:0] DUMMY_QPI_RESET = DUMMY_QPI_SHORT;
  localparam int         PARAM_DUMMY_LSB = 4;
  localparam logic [2:0] BITS_AFTER_ONE  = 3'h7;
  localparam logic [2:0] BITS_AFTER_TWO  = 3'h6;

  // Status byte one and two bit positions
  localparam int SR1_BUSY = 0;
  localparam int SR1_WEL_POS = 1;
  localparam int SR1_LOCK_LOW = 7;
  localparam int SR2_LOCK_HIGH = 0;
  localparam int SR2_QUAD = 1;
  localparam int SR2_INVERT = 6;
  // Same fields within a sixteen-bit 01h payload
  localparam int WIDE_LOCK_LOW = 15;
  localparam int WIDE_LOCK_HIGH = 0;
  localparam int WIDE_QUAD = 1;

  localparam int CLOCK_PERIOD_NS     = 100;
  localparam int STATUS_WRITE_TIME_NS = 15000;
  localparam logic [15:0] STATUS_WRITE_CYCLES =
    16'((STATUS_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  typedef struct packed {
    logic protect_lock_low;
    logic protect_invert;
    logic quad_enable;
    logic protect_lock_high;
  } sfsr_prot_s;

  localparam sfsr_prot_s PROT_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } sfsr_fetch_s;

  typedef enum logic [5:0] {
    ST_OPCODE = 6'h01,
    ST_ADDR   = 6'h02,
    ST_DUMMY  = 6'h04,
    ST_DATA   = 6'h08,
    ST_OUT    = 6'h10,
    ST_IGNORE = 6'h20
  } sfsr_state_e;

endpackage : sfsr_pkg

// ==== sfsr_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps

module sfsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    if (!reset_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule : sfsr_fifo

// ==== sfsr_cmd_properties.sv ====
/* Concurrent checks on the flash command block's pins and status bits.
   Sees top-level ports only; bound to sfsr_cmd below. */
`timescale 1ns/1ps

module sfsr_cmd_properties (
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic                  cs_n,
  input wire logic                  sck,
  input wire logic                  ext_busy,
  input wire logic                  ext_done,
  input wire sfsr_pkg::sfsr_fetch_s fetch,
  input wire logic                  io0_oe,
  input wire logic                  io1_out,
  input wire logic                  io1_oe,
  input wire logic                  write_enable_latch,
  input wire logic                  busy
);
  import sfsr_pkg::*;
  localparam int BUSY_MAX = 152;
  logic [15:0] busy_run;

  // Timed cycle length, own busy only
  always_ff @(posedge clock) begin
    if (!reset_n || !busy || ext_busy)
      busy_run <= 16'h0000;
    else
      busy_run <= busy_run + 16'h0001;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_reset_quiet: assert property ($rose(reset_n) |->
    !write_enable_latch && !busy && !io1_oe && !fetch.req)
    else $error("outputs not idle after reset");
  a_busy_ext: assert property (ext_busy |=> busy)
    else $error("busy missed external busy");
  a_busy_bound: assert property (busy_run <= BUSY_MAX)
    else $error("status write cycle too long");
  a_latch_drop: assert property ($rose(busy) && !$past(ext_busy)
    |-> ##[0:2] !write_enable_latch)
    else $error("latch kept while busy");
  a_done_drop: assert property (cs_n[*6] ##0 ext_done
    |=> !write_enable_latch)
    else $error("latch kept after completion");
  a_deselect_quiet: assert property (cs_n[*5] |-> !io1_oe && !io0_oe)
    else $error("driving while deselected");
  a_shift_fall: assert property ($changed(io1_out) && io1_oe &&
    $past(io1_oe) |-> !$past(sck, 2))
    else $error("output moved off a falling edge");
  a_dual_pair: assert property (io0_oe |-> io1_oe)
    else $error("line zero driven alone");
  a_busy_no_fetch: assert property (busy |-> !fetch.req)
    else $error("array fetch while busy");

  c_busy_end: cover property ($fell(busy));
  c_dual: cover property (io0_oe);
  c_fetch: cover property (fetch.req);
endmodule : sfsr_cmd_properties

bind sfsr_cmd sfsr_cmd_properties u_props (
  .clock, .reset_n, .cs_n, .sck, .ext_busy, .ext_done, .fetch, .io0_oe,
  .io1_out, .io1_oe, .write_enable_latch, .busy
);

// ==== sfsr_host.sv ====
/* Host controller model: mode 0 frames on chip select, clock, line zero.
   Assumes the bench resolves line zero from both drivers. */
`timescale 1ns/1ps

module sfsr_host (
  input wire logic clock,
  input wire logic io1,
  input wire logic io0_wire,
  output logic     cs_n,
  output logic     sck,
  output logic     io0,
  output logic     io0_en
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io0 = 1'b0;
    io0_en = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // Clock idles low between frames; 8 system clocks per bit
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                      input bit dual, output logic [31:0] rx);
    rx = 32'h0000_0000;
    cs_n = 1'b0;
    tick(3);
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) io0 = tx[63-i];
      io0_en = !(dual && i >= ntx - 1);
      tick(4);
      sck = 1'b1;
      if (i >= ntx)
        rx = dual ? {rx[29:0], io1, io0_wire} : {rx[30:0], io1};
      tick(4);
      sck = 1'b0;
    end
    tick(1);
    cs_n = 1'b1;
    io0 = ~io0;
    io0_en = 1'b1;
    tick(6);
  endtask : xfer
endmodule : sfsr_host

// ==== sfsr_cmd_tb.sv ====
/* Self-checking bench for sfsr_cmd: host model on the link, array model
   on the fetch port. Assumes a 10 MHz clock and the host at 800 ns. */
`timescale 1ns/1ps

module sfsr_cmd_tb;
  import sfsr_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        four_wire_command_mode = 1'b0;
  logic        ext_busy = 1'b0;
  logic        ext_done = 1'b0;
  logic        fetch_valid = 1'b0;
  logic [7:0]  fetch_data = 8'h00;
  logic        cs_n, sck, h_io0, h_en, io0_w, io0_out, io0_oe;
  logic        io1_out, io1_oe, write_enable_latch, busy, quad_enable;
  sfsr_fetch_s fetch;
  logic [31:0] rx;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          fetches = 0;

  always #50 clock = ~clock;
  // Undriven line shows the inverse of the host's last bit
  assign io0_w = h_en ? h_io0 : (io0_oe ? io0_out : ~h_io0);

  sfsr_cmd #(.FIFO_DEPTH(8)) u_dut (
    .clock, .reset_n, .cs_n, .sck, .io0_in(io0_w), .io0_out, .io0_oe,
    .io1_out, .io1_oe, .four_wire_command_mode, .ext_busy, .ext_done,
    .fetch, .fetch_valid, .fetch_data, .write_enable_latch, .busy,
    .quad_enable
  );
  sfsr_host u_host (
    .clock, .io1(io1_out), .io0_wire(io0_w), .cs_n, .sck, .io0(h_io0),
    .io0_en(h_en)
  );

  // Array model answers one clock after each request
  always @(posedge clock) begin
    fetch_valid <= fetch.req;
    fetch_data <= mem(fetch.addr);
    if (fetch.req === 1'b1) fetches++;
  end

  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : mem

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic sx(input logic [63:0] tx, input int ntx, input int nrx,
                    input bit dual);
    u_host.xfer(tx, ntx, nrx, dual, rx);
  endtask : sx

  task automatic cmd(input logic [7:0] op);
    sx({op, 56'h0}, 8, 0, 0);
  endtask : cmd

  task automatic rd_sr(input logic [7:0] op, input logic [7:0] e);
    sx({op, 56'h0}, 8, 16, 0);
    check(rx[15:0], {e, e});
  endtask : rd_sr

  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      if (busy === 1'b0) return;
      @(negedge clock);
    end
    error_cnt++;
    $display("ERROR %0t busy stuck", $time);
    finish_test();
  endtask : wait_idle

  task automatic t_wel();
    check(write_enable_latch, 1'b0);
    cmd(OP_VOL_ENABLE);
    check(write_enable_latch, 1'b0);
    rd_sr(OP_READ_SR1, 8'h00);
    cmd(OP_WRITE_ENABLE);
    rd_sr(OP_READ_SR1, 8'h02);
    cmd(OP_WRITE_DISABLE);
    check(write_enable_latch, 1'b0);
    cmd(OP_WRITE_ENABLE);
    ext_done = 1'b1;
    @(negedge clock);
    ext_done = 1'b0;
    @(negedge clock);
    check(write_enable_latch, 1'b0);
  endtask : t_wel

  task automatic wr(input logic [7:0] op, input logic [15:0] d, int n);
    cmd(OP_WRITE_ENABLE);
    sx({op, d, 40'h0}, 8 + n, 0, 0);
    check(busy, 1'b1);
    wait_idle();
  endtask : wr

  task automatic t_sr();
    cmd(OP_WRITE_ENABLE);
    sx({OP_WRITE_SR, 16'hFFFF, 40'h0}, 24, 0, 0);
    sx({OP_READ_SR1, 56'h0}, 8, 8, 0);
    check(rx[7:0], 8'h01);
    wait_idle();
    check(write_enable_latch, 1'b0);
    rd_sr(OP_READ_SR1, 8'h80);
    rd_sr(OP_READ_SR2, 8'h03);
    wr(OP_WRITE_SR2, 16'hFF00, 8);
    rd_sr(OP_READ_SR2, 8'h43);
    wr(OP_WRITE_SR, 16'h8000, 8);
    rd_sr(OP_READ_SR2, 8'h00);
    check(quad_enable, 1'b0);
  endtask : t_sr

  task automatic t_bad();
    sx({OP_WRITE_SR, 16'h0002, 40'h0}, 24, 0, 0);
    check(busy, 1'b0);
    sx({OP_READ_SR1, 56'h0}, 4, 0, 0);
    rd_sr(OP_READ_SR1, 8'h80);
    cmd(OP_WRITE_ENABLE);
    sx({OP_WRITE_SR, 16'h0002, 40'h0}, 20, 0, 0);
    check({busy, quad_enable}, 2'b00);
    cmd(OP_VOL_ENABLE);
    sx({OP_WRITE_SR, 16'h0002, 40'h0}, 24, 0, 0);
    check({busy, quad_enable}, 2'b01);
  endtask : t_bad

  task automatic t_reads();
    int n;
    ext_busy = 1'b1;
    n = fetches;
    sx({OP_READ, 24'h00_0010, 32'h0}, 32, 8, 0);
    check(fetches - n, 0);
    ext_busy = 1'b0;
    @(negedge clock);
    sx({OP_READ, 24'h00_00FE, 32'h0}, 32, 24, 0);
    check(rx[23:0], {8'h5B, 8'h5A, 8'hA5});
    sx({OP_FAST_READ, 24'h00_0040, 32'h0}, 40, 8, 0);
    check(rx[7:0], mem(24'h00_0040));
    sx({OP_DUAL_READ, 24'h00_0020, 32'h0}, 40, 8, 1);
    check(rx[15:0], {mem(24'h00_0020), mem(24'h00_0021)});
  endtask : t_reads

  task automatic t_quad();
    logic [7:0] prm [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
    int         dmy [5] = '{4, 6, 8, 8, 4};
    four_wire_command_mode = 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        cmd(OP_RESET_ENABLE);
        cmd(OP_RESET);
      end else if (k > 0)
        sx({OP_SET_PARAM, prm[k], 48'h0}, 16, 0, 0);
      sx({OP_FAST_READ, 24'h00_0050, 32'h0}, 32 + dmy[k], 8, 0);
      check(rx[7:0], mem(24'h00_0050));
    end
    // Quad mode volatile write with pause and reserved bits high
    cmd(OP_VOL_ENABLE);
    sx({OP_WRITE_SR, 16'h00BE, 40'h0}, 24, 0, 0);
    rd_sr(OP_READ_SR2, 8'h02);
  endtask : t_quad

  initial begin
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    t_wel();
    t_sr();
    t_bad();
    t_reads();
    t_quad();
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    $display("ERROR %0t timeout", $time);
    finish_test();
  end
endmodule : sfsr_cmd_tb
